// File: hw/ufbt_pkg.sv
package ufbt_pkg;

  // ==========================================================
  // register port
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam logic [3:0] CTRL_ADDR = 4'h0;
  localparam logic [3:0] FD_ADDR = 4'h1;
  localparam logic [3:0] STAT_ADDR = 4'h2;

  // ==========================================================
  // control register layout
  localparam int EN_BIT = 7;
  localparam int DIV_MSB = 2;
  localparam int DIV_LSB = 0;
  localparam int DIV_W = 3;
  localparam int FD_W = 8;
  localparam logic [7:0] CTRL_WMASK = 8'h87;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] FD_RST = 8'h00;

  // ==========================================================
  // status register layout
  localparam int STAT_DED_BIT = 0;
  localparam int STAT_TX_T2_BIT = 1;
  localparam int STAT_RX_T2_BIT = 2;

  // ==========================================================
  // legacy control bits
  localparam int SMOD_BIT = 7;
  localparam int TCLK_BIT = 4;
  localparam int RCLK_BIT = 5;

  // ==========================================================
  // divider sizes
  localparam int PRE_W = 7;
  localparam int ACC_W = 10;
  localparam logic [9:0] FRAC_STEP = 10'h040;
  localparam int FRAC_SHIFT = 6;

endpackage

// File: hw/ufbt_tick_if.sv
`timescale 1ns/1ps
interface ufbt_tick_if #(
  parameter int DIV_W = 3,
  parameter int FD_W = 8
);
  logic run;
  logic [DIV_W-1:0] div;
  logic [FD_W-1:0] fd;
  logic pre_tick;
  logic baud_tick;

  modport ctl (output run, output div, output fd,
               input pre_tick, input baud_tick);
  modport pre (input run, input div, output pre_tick);
  modport frac (input run, input fd, input pre_tick, output baud_tick);
endinterface

// File: hw/ufbt_prescaler.sv
`timescale 1ns/1ps
module ufbt_prescaler #(
  parameter int PRE_W = ufbt_pkg::PRE_W
) (
  // clock and reset
  input logic ref_clk,
  input logic rstn,
  // tick path
  ufbt_tick_if.pre io
);

  // ==========================================================
  // power-of-two prescaler
  logic [PRE_W-1:0] cnt_r;
  logic [PRE_W-1:0] cnt_nxt;
  logic [PRE_W-1:0] limit;

  assign limit = PRE_W'((1 << io.div) - 1);
  assign io.pre_tick = io.run && (cnt_r >= limit);
  assign cnt_nxt = (!io.run || io.pre_tick) ? '0 : cnt_r + 1'b1;

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

endmodule

// File: hw/ufbt_frac_div.sv
`timescale 1ns/1ps
module ufbt_frac_div #(
  parameter int ACC_W = ufbt_pkg::ACC_W
) (
  // clock and reset
  input logic ref_clk,
  input logic rstn,
  // tick path
  ufbt_tick_if.frac io
);

  // ==========================================================
  // fractional accumulator, step 64 over fd plus 64
  logic [ACC_W-1:0] acc_r;
  logic [ACC_W-1:0] acc_nxt;
  logic [ACC_W-1:0] sum;
  logic [ACC_W-1:0] modulus;
  logic wrap;
  logic tick_r;

  assign modulus = ACC_W'(io.fd) + ufbt_pkg::FRAC_STEP;
  assign sum = acc_r + ufbt_pkg::FRAC_STEP;
  assign wrap = io.pre_tick && (sum >= modulus);
  assign acc_nxt = !io.run ? '0 :
                   !io.pre_tick ? acc_r :
                   wrap ? sum - modulus : sum;
  assign io.baud_tick = tick_r;

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      acc_r <= '0;
      tick_r <= 1'b0;
    end else begin
      acc_r <= acc_nxt;
      tick_r <= wrap;
    end
  end

endmodule

// File: hw/ufbt_baud_timer.sv
// Design decisions made here: the address map and strobed register access.
`timescale 1ns/1ps
module ufbt_baud_timer #(
  parameter int ADDR_W = ufbt_pkg::ADDR_W,
  parameter int DATA_W = ufbt_pkg::DATA_W
) (
  // clock and reset
  input logic ref_clk,
  input logic rstn,
  // register port
  input logic [ADDR_W-1:0] reg_addr,
  input logic [DATA_W-1:0] reg_wdata,
  input logic reg_wr,
  input logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  // legacy baud sources
  input logic [7:0] power_control_register,
  input logic [7:0] second_timer_control,
  input logic timer1_overflow,
  input logic timer2_overflow,
  // uart 16x bit ticks
  output logic tx_baud_tick,
  output logic rx_baud_tick
);

  // ==========================================================
  // register decode
  logic [DATA_W-1:0] ctrl_r;
  logic [DATA_W-1:0] fd_r;
  logic [DATA_W-1:0] rdata_r;
  logic [DATA_W-1:0] rdata_nxt;
  logic [DATA_W-1:0] stat_word;
  logic ctrl_wr;
  logic fd_wr;
  logic hit_ctrl;
  logic hit_fd;
  logic hit_stat;

  assign hit_ctrl = (reg_addr == ufbt_pkg::CTRL_ADDR);
  assign hit_fd = (reg_addr == ufbt_pkg::FD_ADDR);
  assign hit_stat = (reg_addr == ufbt_pkg::STAT_ADDR);
  assign ctrl_wr = reg_wr && hit_ctrl;
  assign fd_wr = reg_wr && hit_fd;

  // ==========================================================
  // source selection
  logic ded_en;
  logic smod;
  logic tclk_sel;
  logic rclk_sel;
  logic tx_src_t2;
  logic rx_src_t2;
  logic t1_half_r;
  logic t1_tick16;
  logic tx_nxt;
  logic rx_nxt;
  logic tx_r;
  logic rx_r;

  ufbt_tick_if #(
    .DIV_W(ufbt_pkg::DIV_W),
    .FD_W(ufbt_pkg::FD_W)
  ) tio ();

  assign ded_en = ctrl_r[ufbt_pkg::EN_BIT];
  assign smod = power_control_register[ufbt_pkg::SMOD_BIT];
  assign tclk_sel = second_timer_control[ufbt_pkg::TCLK_BIT];
  assign rclk_sel = second_timer_control[ufbt_pkg::RCLK_BIT];
  assign tx_src_t2 = !ded_en && tclk_sel;
  assign rx_src_t2 = !ded_en && rclk_sel;
  assign t1_tick16 = timer1_overflow && (smod || t1_half_r);

  assign tio.run = ded_en;
  assign tio.div = ctrl_r[ufbt_pkg::DIV_MSB:ufbt_pkg::DIV_LSB];
  assign tio.fd = fd_r;

  assign tx_nxt = ded_en ? tio.baud_tick :
                  tx_src_t2 ? timer2_overflow : t1_tick16;
  assign rx_nxt = ded_en ? tio.baud_tick :
                  rx_src_t2 ? timer2_overflow : t1_tick16;

  assign stat_word = {{(DATA_W-3){1'b0}}, rx_src_t2, tx_src_t2, ded_en};
  assign rdata_nxt = !reg_rd ? '0 :
                     hit_ctrl ? ctrl_r :
                     hit_fd ? fd_r :
                     hit_stat ? stat_word : '0;

  assign reg_rdata = rdata_r;
  assign tx_baud_tick = tx_r;
  assign rx_baud_tick = rx_r;

  // ==========================================================
  // divider chain
  ufbt_prescaler #(
    .PRE_W(ufbt_pkg::PRE_W)
  ) u_pre (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .io(tio.pre)
  );

  ufbt_frac_div #(
    .ACC_W(ufbt_pkg::ACC_W)
  ) u_frac (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .io(tio.frac)
  );

  // ==========================================================
  // registers
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      ctrl_r <= ufbt_pkg::CTRL_RST;
      fd_r <= ufbt_pkg::FD_RST;
    end else begin
      if (ctrl_wr) begin
        ctrl_r <= reg_wdata & ufbt_pkg::CTRL_WMASK;
      end
      if (fd_wr) begin
        fd_r <= reg_wdata;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      rdata_r <= '0;
      t1_half_r <= 1'b0;
      tx_r <= 1'b0;
      rx_r <= 1'b0;
    end else begin
      rdata_r <= rdata_nxt;
      if (timer1_overflow) begin
        t1_half_r <= !t1_half_r;
      end
      tx_r <= tx_nxt;
      rx_r <= rx_nxt;
    end
  end

  // ==========================================================
  // checking helpers
  logic [8:0] gap_r;
  logic gap_ok_r;
  logic [7:0] npre_r;
  logic frac_ok_r;
  logic [15:0] npre_scaled;
  logic [15:0] mod_w;

  assign npre_scaled = 16'(npre_r) << ufbt_pkg::FRAC_SHIFT;
  assign mod_w = 16'(tio.fd) + 16'(ufbt_pkg::FRAC_STEP);

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      gap_r <= '0;
      gap_ok_r <= 1'b0;
    end else if (!tio.run || ctrl_wr) begin
      gap_r <= '0;
      gap_ok_r <= 1'b0;
    end else if (tio.pre_tick) begin
      gap_r <= 9'h001;
      gap_ok_r <= 1'b1;
    end else begin
      gap_r <= gap_r + 9'h001;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      npre_r <= '0;
      frac_ok_r <= 1'b0;
    end else if (!tio.run || fd_wr || ctrl_wr) begin
      npre_r <= '0;
      frac_ok_r <= 1'b0;
    end else if (tio.baud_tick) begin
      npre_r <= {7'h00, tio.pre_tick};
      frac_ok_r <= 1'b1;
    end else begin
      npre_r <= npre_r + {7'h00, tio.pre_tick};
    end
  end

  // ==========================================================
  // assertions
  src_dedicated_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    (ded_en && tio.baud_tick) |=> (tx_baud_tick && rx_baud_tick))
    else $error("dedicated tick did not reach uart");

  legacy_ignored_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    (ded_en && !tio.baud_tick) |=> (!tx_baud_tick && !rx_baud_tick))
    else $error("legacy source leaked while dedicated timer enabled");

  legacy_t2_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    (!ded_en && tclk_sel) |-> ##1 (tx_baud_tick == $past(timer2_overflow)))
    else $error("tx tick does not follow second timer overflow");

  legacy_t1_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    (!ded_en && !rclk_sel && timer1_overflow && !smod && !t1_half_r)
      |=> !rx_baud_tick ##0 t1_half_r)
    else $error("first timer overflow not halved with smod clear");

  prescale_period_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    (tio.pre_tick && gap_ok_r) |-> (gap_r == (9'h001 << tio.div)))
    else $error("prescaler period is not a power of two of div");

  frac_ratio_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    (tio.baud_tick && frac_ok_r) |->
      ((npre_scaled + 16'h003F >= mod_w) && (npre_scaled < mod_w + 16'h0040)))
    else $error("fractional divider ratio off");

  frac_rate_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    (tio.run && tio.fd == ufbt_pkg::FD_RST && tio.pre_tick)
      |-> ##1 tio.baud_tick)
    else $error("fd zero must give one tick per prescaled tick");

  ctrl_reserved_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    (reg_rd && hit_ctrl) |=> ((reg_rdata & ~ufbt_pkg::CTRL_WMASK) == '0))
    else $error("reserved control bits read nonzero");

  ctrl_write_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    ctrl_wr |=> (ctrl_r == ($past(reg_wdata) & ufbt_pkg::CTRL_WMASK)))
    else $error("control write not stored masked");

  stat_read_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    (reg_rd && hit_stat && !ctrl_wr) |=>
      (reg_rdata[ufbt_pkg::STAT_DED_BIT] == ded_en))
    else $error("status does not show dedicated enable");

  idle_off_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    !tio.run |-> ##1 !tio.baud_tick)
    else $error("divider ticks while disabled");

  fd_write_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    fd_wr |=> (fd_r == $past(reg_wdata)))
    else $error("fractional divide write not stored");

  ded_same_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    ded_en |=> (tx_baud_tick == rx_baud_tick))
    else $error("tx and rx ticks differ while dedicated timer enabled");

  stat_ignore_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    (reg_rd && hit_stat && ded_en) |=>
      (reg_rdata[ufbt_pkg::STAT_TX_T2_BIT] == 1'b0 &&
       reg_rdata[ufbt_pkg::STAT_RX_T2_BIT] == 1'b0))
    else $error("status shows second timer source while enabled");

  legacy_t1_tx_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    (!ded_en && !tclk_sel && timer1_overflow && smod) |=> tx_baud_tick)
    else $error("first timer overflow lost with smod set");

  legacy_rx_t2_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    (!ded_en && rclk_sel) |-> ##1 (rx_baud_tick == $past(timer2_overflow)))
    else $error("rx tick does not follow second timer overflow");

  // ==========================================================
  // covers
  ded_tick_c: cover property (
    @(posedge ref_clk) disable iff (!rstn)
    ded_en && tio.baud_tick ##1 tx_baud_tick);

  legacy_t2_c: cover property (
    @(posedge ref_clk) disable iff (!rstn)
    tx_src_t2 && timer2_overflow ##1 tx_baud_tick);

  legacy_rx_t2_c: cover property (
    @(posedge ref_clk) disable iff (!rstn)
    rx_src_t2 && timer2_overflow ##1 rx_baud_tick);

  legacy_t1_c: cover property (
    @(posedge ref_clk) disable iff (!rstn)
    !ded_en && !smod && t1_tick16 ##1 rx_baud_tick);

  frac_wrap_c: cover property (
    @(posedge ref_clk) disable iff (!rstn)
    tio.baud_tick && frac_ok_r && npre_r > 8'h01);

endmodule

// File: test/ufbt_uart_model.sv
`timescale 1ns/1ps
// ==========================================================
// uart shifter side: totals of 16x ticks
module ufbt_uart_model (
  // clock
  input logic ref_clk,
  // ticks from the timer
  input logic tx_baud_tick,
  input logic rx_baud_tick,
  // tick totals
  output int tx_cnt,
  output int rx_cnt
);
  int tx_n = 0;
  int rx_n = 0;

  assign tx_cnt = tx_n;
  assign rx_cnt = rx_n;

  always @(posedge ref_clk) begin
    if (tx_baud_tick === 1'b1) tx_n <= tx_n + 1;
    if (rx_baud_tick === 1'b1) rx_n <= rx_n + 1;
  end
endmodule

// File: test/uart_fractional_baud_timer_tb_top.sv
`timescale 1ns/1ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin \
  n_errors++; $display("unexpected t=%0t got %0h exp %0h", \
  $time, a, e); end end
module uart_fractional_baud_timer_tb_top;
  // ==========================================================
  // stimulus and observed signals
  typedef struct {
    logic [7:0] ctl;
    logic [7:0] fd;
    logic [7:0] pw;
    logic [7:0] t2;
    int tx;
    int rx;
  } ufbt_row_s;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic [7:0] pw_ctl = 8'h00;
  logic [7:0] t2_ctl = 8'h00;
  logic t1_ovf = 1'b0;
  logic t2_ovf = 1'b0;
  logic tx_tick;
  logic rx_tick;
  int tx_cnt;
  int rx_cnt;
  int n_errors = 0;
  int comparisons = 0;
  int cyc = 0;
  // window of 768 cycles; expected totals from the rate formula
  ufbt_row_s rows[8] = '{
    '{8'h80, 8'h00, 8'h80, 8'h30, 768, 768},
    '{8'h82, 8'h00, 8'h00, 8'h30, 192, 192},
    '{8'h81, 8'h40, 8'h80, 8'h00, 192, 192},
    '{8'h81, 8'h20, 8'h00, 8'h30, 256, 256},
    '{8'h83, 8'h09, 8'h80, 8'h30, 84, 84},
    '{8'h87, 8'hFF, 8'h00, 8'h00, 1, 1},
    '{8'h00, 8'h00, 8'h80, 8'h20, 154, 256},
    '{8'h00, 8'h00, 8'h00, 8'h10, 256, 77}};

  always #5 ref_clk = ~ref_clk;

  // ==========================================================
  // legacy overflow sources: first every 5, second every 3
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    t1_ovf <= (cyc % 5 == 0);
    t2_ovf <= (cyc % 3 == 0);
  end

  ufbt_baud_timer dut (
    .ref_clk(ref_clk), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .power_control_register(pw_ctl),
    .second_timer_control(t2_ctl), .timer1_overflow(t1_ovf),
    .timer2_overflow(t2_ovf), .tx_baud_tick(tx_tick),
    .rx_baud_tick(rx_tick));

  ufbt_uart_model uart (
    .ref_clk(ref_clk), .tx_baud_tick(tx_tick),
    .rx_baud_tick(rx_tick), .tx_cnt(tx_cnt), .rx_cnt(rx_cnt));

  // ==========================================================
  // register port tasks
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    `CHK(reg_rdata, e)
  endtask

  // tick totals over one window, one tick of slack for phase
  task automatic win(input int etx, input int erx);
    int t0;
    int r0;
    int dtx;
    int drx;
    repeat (8) @(posedge ref_clk);
    t0 = tx_cnt;
    r0 = rx_cnt;
    repeat (768) @(posedge ref_clk);
    dtx = tx_cnt - t0 - etx;
    drx = rx_cnt - r0 - erx;
    `CHK((dtx >= -1) && (dtx <= 1), 1'b1)
    `CHK((drx >= -1) && (drx <= 1), 1'b1)
  endtask

  task automatic wrap_up;
    $display("errors %0d of %0d checks", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // ==========================================================
  // main sequence
  initial begin
    repeat (2) @(posedge ref_clk);
    rstn <= 1'b1;
    rd(4'h0, 8'h00);
    rd(4'h1, 8'h00);
    foreach (rows[i]) begin
      wr(4'h1, rows[i].fd);
      pw_ctl <= rows[i].pw;
      t2_ctl <= rows[i].t2;
      wr(4'h0, rows[i].ctl);
      win(rows[i].tx, rows[i].rx);
    end
    wr(4'h0, 8'hFF);
    rd(4'h0, 8'h87);
    wr(4'h1, 8'h2D);
    rd(4'h1, 8'h2D);
    wr(4'h3, 8'hFF);
    rd(4'h3, 8'h00);
    rd(4'h0, 8'h87);
    rd(4'h2, 8'h01);
    @(posedge ref_clk);
    rstn <= 1'b0;
    @(posedge ref_clk);
    rstn <= 1'b1;
    rd(4'h0, 8'h00);
    rd(4'h1, 8'h00);
    rd(4'h2, 8'h02);
    wrap_up();
  end
endmodule
